/* rtl/csc_pkg.sv */
package csc_pkg;

  localparam logic [11:0] OFS_MAX_CORR    = 12'h5A0;
  localparam logic [11:0] OFS_CAM_START   = 12'h5A2;
  localparam logic [11:0] OFS_CAM_AREAS   = 12'h5A4;
  localparam logic [11:0] OFS_CAM_CYCLES  = 12'h5A6;
  localparam logic [11:0] OFS_CAM_MPULSE  = 12'h5A8;
  localparam logic [11:0] OFS_SYNC_IVAL   = 12'h59C;
  localparam logic [11:0] OFS_SYNC_ERR    = 12'h59E;
  localparam logic [11:0] OFS_SYNC_POS    = 12'h59A;
  localparam logic [11:0] OFS_CAM_CTRL    = 12'h5B0;

  localparam logic [15:0] RST_MAX_CORR    = 16'h000A;
  localparam logic [15:0] RST_CAM_START   = 16'h0064;
  localparam logic [15:0] RST_CAM_AREAS   = 16'h0005;
  localparam logic [15:0] RST_CAM_CYCLES  = 16'h0001;
  localparam logic [31:0] RST_CAM_MPULSE  = 32'h00000E10;
  localparam logic [31:0] RST_SYNC_IVAL   = 32'h00000064;

  localparam logic [15:0] MAX_CORR_LIMIT  = 16'h005A;
  localparam logic [15:0] ARRAY_SIZE      = 16'h0320;
  localparam logic [15:0] AREAS_MIN       = 16'h0005;
  localparam logic [15:0] AREAS_MAX       = 16'h02D0;
  localparam logic [15:0] CYCLES_MAX      = 16'h7FFF;
  localparam logic [31:0] MPULSE_MAX      = 32'h3FFFFFFF;
  localparam logic [47:0] PRODUCT_MAX     = 48'h00007FFFFFFF;
  localparam logic [7:0]  PERCENT_FULL    = 8'h64;

  localparam int          CTRL_EN_BIT     = 0;
  localparam int          CTRL_ENG_BIT    = 1;
  localparam int          CTRL_NEWFW_BIT  = 2;

  typedef struct packed {
    logic        sample;
    logic        capture;
  } csc_evt_t;

endpackage

/* rtl/csc_top.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - Error equals output count minus interval times captures
// - Error refreshed once per axis run after capture
// - Written error is added to target position offset
// - Rate band 100 plus/minus setting, 0..90; code corrects at 100 plus/minus (setting minus 1)
// - Rate is output over input, steer error zero
// - Start address picks first point, 0..800-N
// - Older mode: start locked while cam enabled
// - Newer mode: start applied only while engaged
// - N areas read N points
// - Areas 5..720, fit array, product bounded
// - Areas, cycles, pulses writable only when stopped
// - M table cycles per P master pulses
module csc_top
  import csc_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [13:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        master_pulse_pin,
  input  wire logic        capture_pin,
  output logic             sync_step,
  output logic      [9:0]  cam_point_addr,
  output logic      [15:0] cam_cycles_done
);

  typedef struct packed {
    logic [2:0]  mp_s;
    logic [2:0]  cp_s;
    logic [15:0] max_corr;
    logic [15:0] start_req;
    logic [15:0] start_act;
    logic [15:0] areas;
    logic [15:0] cycles;
    logic [31:0] mpulse;
    logic [31:0] ival;
    logic [31:0] err;
    logic [31:0] pos;
    logic [31:0] offset;
    logic [47:0] ideal;
    logic        cap_pend;
    logic [2:0]  ctrl;
    logic [7:0]  acc_in;
    logic [8:0]  acc_out;
    logic [47:0] phase;
    logic [15:0] area_idx;
    logic [15:0] cyc_done;
    logic        step;
    logic [31:0] rdata;
    logic        ready;
    logic        slverr;
    logic [9:0]  point;
  } csc_state_t;

  csc_state_t st_r;
  csc_state_t st_nxt;

  // Register index is the word address
  function automatic logic sel(input logic [13:0] a, input logic [11:0] o);
    sel = (a[13:2] == o);
  endfunction

  logic        mp_rise;
  logic        cp_rise;
  logic        cam_stopped;
  logic        wr_go;
  logic [47:0] prod;
  logic [31:0] diff;
  logic [7:0]  band_lo;
  logic [7:0]  band_hi;
  logic [15:0] area_len;

  assign mp_rise  = st_r.mp_s[1] & ~st_r.mp_s[2];
  assign cp_rise  = st_r.cp_s[1] & ~st_r.cp_s[2];
  assign cam_stopped = ~st_r.ctrl[CTRL_EN_BIT];
  assign wr_go    = psel & penable & pwrite;
  assign band_lo  = PERCENT_FULL - st_r.max_corr[7:0];
  assign band_hi  = PERCENT_FULL + st_r.max_corr[7:0];
  assign area_len = (st_r.areas == 16'h0000) ? 16'h0001 : st_r.areas;

  always_comb begin
    st_nxt = st_r;
    st_nxt.mp_s = {st_r.mp_s[1:0], master_pulse_pin};
    st_nxt.cp_s = {st_r.cp_s[1:0], capture_pin};
    st_nxt.step = 1'b0;
    st_nxt.ready = 1'b0;
    st_nxt.slverr = 1'b0;
    prod = 48'h0;
    diff = 32'h0;
    if (cp_rise) begin
      st_nxt.cap_pend = 1'b1;
      st_nxt.ideal = st_r.ideal + {16'h0000, st_r.ival};
    end
    if (mp_rise) begin
      st_nxt.acc_in = st_r.acc_in + 8'h01;
      diff = st_r.pos - st_r.ideal[31:0] - st_r.offset;
      if ($signed(diff) < 0)
        st_nxt.acc_out = st_r.acc_out + {1'b0, band_hi} - 9'h001;
      else if ($signed(diff) > 0)
        st_nxt.acc_out = st_r.acc_out + {1'b0, band_lo} + 9'h001;
      else
        st_nxt.acc_out = st_r.acc_out + {1'b0, PERCENT_FULL};
    end
    if (st_r.acc_out >= {1'b0, PERCENT_FULL} && !mp_rise) begin
      st_nxt.acc_out = st_r.acc_out - {1'b0, PERCENT_FULL};
      st_nxt.step = 1'b1;
      st_nxt.pos = st_r.pos + 32'h1;
      if (st_r.cap_pend) begin
        st_nxt.cap_pend = 1'b0;
        st_nxt.err = st_r.pos + 32'h1 - st_r.ideal[31:0];
      end
    end
    if (mp_rise && !cam_stopped) begin
      st_nxt.phase = st_r.phase + {32'h0, st_r.cycles} * {16'h0, area_len};
      prod = {16'h0, st_r.mpulse};
      if (st_nxt.phase >= prod) begin
        st_nxt.phase = st_nxt.phase - prod;
        if (st_r.area_idx >= st_r.areas - 16'h1) begin
          st_nxt.area_idx = 16'h0;
          st_nxt.cyc_done = st_r.cyc_done + 16'h1;
        end else begin
          st_nxt.area_idx = st_r.area_idx + 16'h1;
        end
      end
    end
    if (st_r.ctrl[CTRL_ENG_BIT])
      st_nxt.start_act = st_r.start_req;
    if (psel && !penable) begin
      st_nxt.ready = 1'b1;
      st_nxt.rdata = 32'h0;
      if (sel(paddr, OFS_MAX_CORR)) st_nxt.rdata = {16'h0, st_r.max_corr};
      else if (sel(paddr, OFS_CAM_START)) st_nxt.rdata = {16'h0, st_r.start_req};
      else if (sel(paddr, OFS_CAM_AREAS)) st_nxt.rdata = {16'h0, st_r.areas};
      else if (sel(paddr, OFS_CAM_CYCLES)) st_nxt.rdata = {16'h0, st_r.cycles};
      else if (sel(paddr, OFS_CAM_MPULSE)) st_nxt.rdata = st_r.mpulse;
      else if (sel(paddr, OFS_SYNC_IVAL)) st_nxt.rdata = st_r.ival;
      else if (sel(paddr, OFS_SYNC_ERR)) st_nxt.rdata = st_r.err;
      else if (sel(paddr, OFS_SYNC_POS)) st_nxt.rdata = st_r.pos;
      else if (sel(paddr, OFS_CAM_CTRL)) st_nxt.rdata = {29'h0, st_r.ctrl};
      else st_nxt.slverr = 1'b1;
      if (pwrite) begin
        st_nxt.rdata = 32'h0;
        if (sel(paddr, OFS_MAX_CORR)) begin
          if (pwdata[15:0] > MAX_CORR_LIMIT || pwdata[31:16] != 16'h0) st_nxt.slverr = 1'b1;
        end else if (sel(paddr, OFS_CAM_START)) begin
          if ({16'h0, pwdata[15:0]} > {16'h0, ARRAY_SIZE - st_r.areas} || pwdata[31:16] != 16'h0)
            st_nxt.slverr = 1'b1;
          if (!st_r.ctrl[CTRL_NEWFW_BIT] && st_r.ctrl[CTRL_EN_BIT]) st_nxt.slverr = 1'b1;
        end else if (sel(paddr, OFS_CAM_AREAS)) begin
          prod = {16'h0, pwdata[15:0]} * {16'h0, st_r.mpulse};
          if (pwdata[15:0] < AREAS_MIN || pwdata[15:0] > AREAS_MAX || pwdata[31:16] != 16'h0
              || pwdata[15:0] > ARRAY_SIZE - st_r.start_req || prod > PRODUCT_MAX)
            st_nxt.slverr = 1'b1;
          if (!cam_stopped) st_nxt.slverr = 1'b1;
        end else if (sel(paddr, OFS_CAM_CYCLES)) begin
          if (pwdata[15:0] == 16'h0 || pwdata[15:0] > CYCLES_MAX || pwdata[31:16] != 16'h0)
            st_nxt.slverr = 1'b1;
          if (!cam_stopped) st_nxt.slverr = 1'b1;
        end else if (sel(paddr, OFS_CAM_MPULSE)) begin
          prod = {32'h0, st_r.areas} * {16'h0, pwdata};
          if (pwdata > MPULSE_MAX || prod > PRODUCT_MAX) st_nxt.slverr = 1'b1;
          if (!cam_stopped) st_nxt.slverr = 1'b1;
        end
      end
    end
    if (wr_go && st_r.ready && !st_r.slverr) begin
      if (sel(paddr, OFS_MAX_CORR)) st_nxt.max_corr = pwdata[15:0];
      else if (sel(paddr, OFS_CAM_START)) st_nxt.start_req = pwdata[15:0];
      else if (sel(paddr, OFS_CAM_AREAS)) st_nxt.areas = pwdata[15:0];
      else if (sel(paddr, OFS_CAM_CYCLES)) st_nxt.cycles = pwdata[15:0];
      else if (sel(paddr, OFS_CAM_MPULSE)) st_nxt.mpulse = pwdata;
      else if (sel(paddr, OFS_SYNC_IVAL)) st_nxt.ival = pwdata;
      else if (sel(paddr, OFS_CAM_CTRL)) begin
        st_nxt.ctrl = pwdata[2:0];
        if (!pwdata[CTRL_EN_BIT]) begin
          st_nxt.area_idx = 16'h0;
          st_nxt.phase = 48'h0;
          st_nxt.cyc_done = 16'h0;
        end
      end else if (sel(paddr, OFS_SYNC_ERR)) begin
        st_nxt.offset = st_r.offset + pwdata;
        st_nxt.err = pwdata;
      end
    end
    st_nxt.point = st_nxt.start_act[9:0] + st_nxt.area_idx[9:0];
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '0;
      st_r.point <= RST_CAM_START[9:0];
      st_r.max_corr <= RST_MAX_CORR;
      st_r.start_req <= RST_CAM_START;
      st_r.start_act <= RST_CAM_START;
      st_r.areas <= RST_CAM_AREAS;
      st_r.cycles <= RST_CAM_CYCLES;
      st_r.mpulse <= RST_CAM_MPULSE;
      st_r.ival <= RST_SYNC_IVAL;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata          = st_r.rdata;
  assign pready          = st_r.ready;
  assign pslverr         = st_r.slverr;
  assign sync_step       = st_r.step;
  assign cam_point_addr  = st_r.point;
  assign cam_cycles_done = st_r.cyc_done;

endmodule // csc_top

/* test/csc_chk_sva.sv */
`timescale 1ns/1ps
module csc_chk
  import csc_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [9:0]  cam_point_addr,
  input wire logic [15:0] cam_cycles_done
);
  logic wr;
  logic en_r;
  logic en_nxt;
  assign wr = psel && penable && pready && pwrite;
  // Tracks the cam enable bit
  always_comb begin
    en_nxt = en_r;
    if (wr && !pslverr && paddr == {OFS_CAM_CTRL, 2'b00}) begin
      en_nxt = pwdata[CTRL_EN_BIT];
    end
  end
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      en_r <= 1'b0;
    end else begin
      en_r <= en_nxt;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  corr_range_a: assert property (wr && paddr == {OFS_MAX_CORR, 2'b00} && pwdata > 32'h5A |-> pslverr)
    else $error("rate limit accepted");
  start_range_a: assert property (wr && paddr == {OFS_CAM_START, 2'b00} && pwdata > 32'h31B |-> pslverr)
    else $error("start accepted");
  areas_range_a: assert property (wr && paddr == {OFS_CAM_AREAS, 2'b00} && (pwdata < 32'h5 || pwdata > 32'h2D0) |-> pslverr)
    else $error("area count accepted");
  mpulse_range_a: assert property (wr && paddr == {OFS_CAM_MPULSE, 2'b00} && pwdata > 32'h3FFFFFFF |-> pslverr)
    else $error("pulse count accepted");
  stopped_write_a: assert property (wr && en_r && paddr == {OFS_CAM_AREAS, 2'b00} |-> pslverr)
    else $error("area write while enabled");
  point_bound_a: assert property (cam_point_addr <= 10'h320)
    else $error("point outside array");
  cycle_step_a: assert property (cam_cycles_done != $past(cam_cycles_done) |->
    cam_cycles_done == $past(cam_cycles_done) + 16'h0001 || cam_cycles_done == 16'h0000) else $error("cycle jump");
  err_ready_a: assert property (pslverr |-> pready && psel && penable && $past(psel) && !$past(penable))
    else $error("stray error");
endmodule // csc_chk

bind csc_top csc_chk i_chk (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .cam_point_addr(cam_point_addr), .cam_cycles_done(cam_cycles_done));

/* test/csc_master_src.sv */
`timescale 1ns/1ps
module csc_master_src (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        run,
  output logic             master_pulse_pin,
  output logic             capture_pin,
  output logic      [15:0] pulses
);
  logic [2:0] ph;
  // Whole pulses only, capture on pulses 4n and 4n+1
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ph <= 3'h0;
      pulses <= 16'h0000;
      master_pulse_pin <= 1'b0;
      capture_pin <= 1'b0;
    end else if (run || ph != 3'h0) begin
      ph <= ph + 3'h1;
      master_pulse_pin <= (ph < 3'h4);
      capture_pin <= (ph < 3'h4) && (pulses[1:0] == 2'h0);
      if (ph == 3'h0) begin
        pulses <= pulses + 16'h0001;
      end
    end
  end
endmodule // csc_master_src

/* test/test_csc_top.sv */
`timescale 1ns/1ps
module test_csc_top;
  import csc_pkg::*;
  typedef struct packed {
    logic        rd;
    logic        err;
    logic [31:0] data;
  } csc_note_t;
  logic        core_clk, sys_rst, psel, penable, pwrite, pready, pslverr, run, mpin, cpin, sync_step;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [9:0]  cam_point_addr;
  logic [15:0] cam_cycles_done, pulses;
  int          n_errors, tests_run, steps, n;
  csc_note_t   notes[$];

  csc_top i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .master_pulse_pin(mpin), .capture_pin(cpin), .sync_step(sync_step),
    .cam_point_addr(cam_point_addr), .cam_cycles_done(cam_cycles_done));
  csc_master_src i_src (.core_clk(core_clk), .sys_rst(sys_rst), .run(run), .master_pulse_pin(mpin),
    .capture_pin(cpin), .pulses(pulses));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic e);
    int k;
    notes.push_back('{~w & ~e, e, d});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {a, 2'b00};
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) n_errors++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  // Result watcher
  always @(posedge core_clk) begin
    if (sync_step === 1'b1) steps++;
    if (psel && penable && pready === 1'b1 && notes.size() > 0) begin
      chk({31'h0, pslverr}, {31'h0, notes[0].err});
      if (notes[0].rd) chk(prdata, notes[0].data);
      void'(notes.pop_front());
    end
  end

  task test_done;
    $display("errors=%0d checks=%0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    #200000;
    n_errors++;
    test_done;
  end

  initial begin
    {sys_rst, psel, penable, pwrite, run, paddr, pwdata} = {1'b1, 4'h0, 14'h0, 32'h0};
    {n_errors, tests_run, steps} = 0;
    void'($urandom(17159));
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    chk({22'h0, cam_point_addr}, 32'h64);
    apb(0, OFS_MAX_CORR, 32'hA, 0);
    apb(0, OFS_CAM_START, 32'h64, 0);
    apb(0, OFS_CAM_AREAS, 32'h5, 0);
    apb(0, OFS_CAM_MPULSE, 32'hE10, 0);
    apb(1, OFS_MAX_CORR, 32'h5A, 0);
    apb(1, OFS_MAX_CORR, 32'h5B, 1);
    apb(0, OFS_MAX_CORR, 32'h5A, 0);
    apb(1, OFS_CAM_AREAS, 32'h4, 1);
    apb(1, OFS_CAM_AREAS, 32'h2D0, 1);
    apb(1, OFS_CAM_START, 32'h50, 0);
    apb(1, OFS_CAM_AREAS, 32'h2D1, 1);
    apb(1, OFS_CAM_AREAS, 32'h2D0, 0);
    r = 32'hA + $urandom % 32'h2D82CF;
    apb(1, OFS_CAM_MPULSE, r, 0);
    apb(1, OFS_CAM_MPULSE, 32'h2D82D9, 1);
    apb(1, OFS_CAM_MPULSE, 32'h40000000, 1);
    apb(0, OFS_CAM_MPULSE, r, 0);
    apb(1, OFS_CAM_AREAS, 32'h5, 0);
    apb(1, OFS_CAM_START, 32'h64, 0);
    apb(1, OFS_CAM_MPULSE, 32'hA, 0);
    apb(1, OFS_CAM_CTRL, 32'h3, 0);
    apb(1, OFS_CAM_START, 32'h64, 1);
    apb(1, OFS_CAM_AREAS, 32'h6, 1);
    apb(1, OFS_CAM_MPULSE, 32'h14, 1);
    run <= 1'b1;
    for (n = 0; n < 2000 && pulses != 16'd25; n++) @(posedge core_clk);
    run <= 1'b0;
    repeat (40) @(posedge core_clk);
    chk({16'h0, cam_cycles_done}, 32'h2);
    chk({22'h0, cam_point_addr}, 32'h66);
    chk({31'h0, steps > 0}, 32'h1);
    apb(1, OFS_CAM_CTRL, 32'h0, 0);
    apb(1, OFS_CAM_AREAS, 32'h6, 0);
    apb(0, OFS_CAM_AREAS, 32'h6, 0);
    test_done;
  end
endmodule // test_csc_top
